// ==== ddc_front_pkg.sv ====
/*
 Shared constants of the down-conversion front: register indices, field positions,
 reset values, mixer modes and datapath widths.
 Assumes nothing of its surroundings.
*/
package ddc_front_pkg;
    // Datapath widths
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned OSC_W = 8;
    localparam int unsigned PROD_W = 24;
    localparam int unsigned WORD_W = 7;
    localparam int unsigned NUM_OSC = 3;
    localparam int unsigned BUF_W = 19;
    // Bus widths; byte address is four times the register index
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned IDX_W = 9;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices
    localparam logic [8:0] IDX_OSC_DITHER [3] = '{9'h100, 9'h107, 9'h10e};
    localparam logic [8:0] IDX_OSC_FREQ [3] = '{9'h105, 9'h10c, 9'h113};
    localparam logic [8:0] IDX_OSC_PHASE [3] = '{9'h106, 9'h10d, 9'h114};
    localparam logic [8:0] IDX_MIX_SELECT = 9'h115;
    localparam logic [8:0] IDX_DATAPATH = 9'h116;

    ////////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam int unsigned DITHER_BIT = 0;
    localparam int unsigned WORD_MSB = 6;
    localparam int unsigned TONES_LSB = 5;
    localparam int unsigned TONES_MSB = 6;
    localparam int unsigned JSRC_BIT = 4;
    localparam int unsigned BURST_BIT = 2;
    localparam logic RST_DITHER = 1'h1;
    localparam logic [6:0] RST_WORD = 7'h00;
    localparam logic [1:0] RST_TONES = 2'h3;
    localparam logic RST_JSRC = 1'h0;
    localparam logic RST_BURST = 1'h1;

    typedef enum logic [1:0] {
        MIX_NORMAL = 2'b00,
        MIX_BYPASS = 2'b01,
        MIX_RSVD = 2'b10,
        MIX_TEST = 2'b11
    } mix_mode_t;

    // Test tone amplitude and dither generator seed
    localparam logic signed [15:0] TEST_CONST = 16'sh4000;
    localparam logic [7:0] LFSR_SEED = 8'h5a;
    localparam int unsigned PROD_LSB = 7;
    localparam logic [7:0] TRI_OFFSET = 8'h40;
endpackage : ddc_front_pkg

// ==== ddc_skid_buf.sv ====
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ddc_skid_buf #(
    parameter int unsigned W = 19
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    logic [W-1:0] head_ff;
    logic [W-1:0] tail_ff;
    logic head_v_ff;
    logic tail_v_ff;
    logic rdy_ff;
    logic [W-1:0] nxt_head;
    logic [W-1:0] nxt_tail;
    logic nxt_head_v;
    logic nxt_tail_v;
    logic push;
    logic pop;

    assign push = in_valid_i & rdy_ff;
    assign pop = head_v_ff & out_ready_i;
    assign in_ready_o = rdy_ff;
    assign out_data_o = head_ff;
    assign out_valid_o = head_v_ff;

    always_comb begin
        nxt_head = head_ff;
        nxt_tail = tail_ff;
        nxt_head_v = head_v_ff;
        nxt_tail_v = tail_v_ff;
        if (pop) begin
            if (tail_v_ff) begin
                nxt_head = tail_ff;
                nxt_tail = in_data_i;
                nxt_tail_v = push;
            end else begin
                nxt_head = in_data_i;
                nxt_head_v = push;
            end
        end else if (push) begin
            if (!head_v_ff) begin
                nxt_head = in_data_i;
                nxt_head_v = 1'b1;
            end else begin
                nxt_tail = in_data_i;
                nxt_tail_v = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            head_v_ff <= 1'b0;
            tail_v_ff <= 1'b0;
            rdy_ff <= 1'b0;
            head_ff <= '0;
            tail_ff <= '0;
        end else begin
            head_v_ff <= nxt_head_v;
            tail_v_ff <= nxt_tail_v;
            // Full only when the second entry holds a word
            rdy_ff <= ~nxt_tail_v;
            head_ff <= nxt_head;
            tail_ff <= nxt_tail;
        end
    end
endmodule : ddc_skid_buf
`default_nettype wire

// ==== ddc_front.sv ====
/*
 Down-conversion front: three tone oscillators, the mixer, path selection and the
 register file on an Avalon-MM slave with waitrequest.
 Assumes samples arrive on clk_i with valid/ready and one master on the bus.
*/
`timescale 1ns/10ps
`default_nettype none
module ddc_front (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register bus
    input wire logic [10:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Sample input
    input wire logic [15:0] sample_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    // Mixed output
    output logic [15:0] result_o,
    output logic result_gh_path_o,
    output logic [1:0] result_tone_o,
    output logic result_valid_o,
    input wire logic result_ready_i,
    // Static path state
    output logic j_raw_source_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0] dither_on_ff;
    logic [6:0] tuning_word_ff [3];
    logic [6:0] phase_shift_ff [3];
    logic [6:0] phase_acc_ff [3];
    logic [1:0] mix_mode_ff;
    logic [1:0] tone_count_ff;
    logic j_input_source_select_ff;
    logic burst_select_ff;
    logic [1:0] tone_idx_ff;
    logic [7:0] lfsr_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;

    logic [8:0] req_idx;
    logic req;
    logic wr_take;
    logic [7:0] rd_byte;
    logic addr_ok;
    logic push;
    logic buf_ready;
    logic [1:0] tones_eff;
    logic signed [7:0] osc_val [3];
    logic signed [7:0] osc_sel;
    logic signed [23:0] prod;
    logic signed [23:0] test_prod;
    logic [15:0] mixed;
    logic [15:0] path_data;
    logic [18:0] buf_in;
    logic [18:0] buf_out;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: one wait state, then the answer
    assign req = avs_read_i | avs_write_i;
    assign req_idx = avs_address_i[ddc_front_pkg::ADDR_W-1:2];
    assign wr_take = avs_write_i & ~wait_ff & avs_byteenable_i[0] & addr_ok;

    always_comb begin
        rd_byte = 8'h00;
        addr_ok = (avs_address_i[1:0] == 2'b00);
        if (addr_ok) begin
            addr_ok = 1'b0;
            for (int i = 0; i < 3; i++) begin
                if (req_idx == ddc_front_pkg::IDX_OSC_DITHER[i]) begin
                    rd_byte = {7'h00, dither_on_ff[i]};
                    addr_ok = 1'b1;
                end
                if (req_idx == ddc_front_pkg::IDX_OSC_FREQ[i]) begin
                    rd_byte = {1'b0, tuning_word_ff[i]};
                    addr_ok = 1'b1;
                end
                if (req_idx == ddc_front_pkg::IDX_OSC_PHASE[i]) begin
                    rd_byte = {1'b0, phase_shift_ff[i]};
                    addr_ok = 1'b1;
                end
            end
            if (req_idx == ddc_front_pkg::IDX_MIX_SELECT) begin
                rd_byte = {6'h00, mix_mode_ff};
                addr_ok = 1'b1;
            end
            if (req_idx == ddc_front_pkg::IDX_DATAPATH) begin
                rd_byte = {1'b0, tone_count_ff, j_input_source_select_ff, 1'b0, burst_select_ff, 2'b00};
                addr_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (req & wait_ff) begin
                rdata_ff <= {24'h000000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; only the documented bits are stored
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                dither_on_ff[i] <= ddc_front_pkg::RST_DITHER;
                tuning_word_ff[i] <= ddc_front_pkg::RST_WORD;
                phase_shift_ff[i] <= ddc_front_pkg::RST_WORD;
            end
            mix_mode_ff <= ddc_front_pkg::MIX_NORMAL;
            tone_count_ff <= ddc_front_pkg::RST_TONES;
            j_input_source_select_ff <= ddc_front_pkg::RST_JSRC;
            burst_select_ff <= ddc_front_pkg::RST_BURST;
        end else if (wr_take) begin
            for (int i = 0; i < 3; i++) begin
                if (req_idx == ddc_front_pkg::IDX_OSC_DITHER[i]) begin
                    dither_on_ff[i] <= avs_writedata_i[ddc_front_pkg::DITHER_BIT];
                end
                if (req_idx == ddc_front_pkg::IDX_OSC_FREQ[i]) begin
                    tuning_word_ff[i] <= avs_writedata_i[ddc_front_pkg::WORD_MSB:0];
                end
                if (req_idx == ddc_front_pkg::IDX_OSC_PHASE[i]) begin
                    phase_shift_ff[i] <= avs_writedata_i[ddc_front_pkg::WORD_MSB:0];
                end
            end
            if (req_idx == ddc_front_pkg::IDX_MIX_SELECT) begin
                mix_mode_ff <= avs_writedata_i[1:0];
            end
            if (req_idx == ddc_front_pkg::IDX_DATAPATH) begin
                tone_count_ff <= avs_writedata_i[ddc_front_pkg::TONES_MSB:ddc_front_pkg::TONES_LSB];
                j_input_source_select_ff <= avs_writedata_i[ddc_front_pkg::JSRC_BIT];
                burst_select_ff <= avs_writedata_i[ddc_front_pkg::BURST_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillators: triangle from phase, dither on the lowest bit
    assign push = sample_valid_i & buf_ready;

    always_comb begin
        logic [6:0] ph;
        logic [5:0] tri_v;
        ph = 7'h00;
        tri_v = 6'h00;
        for (int i = 0; i < 3; i++) begin
            ph = 7'(phase_acc_ff[i] + phase_shift_ff[i]);
            tri_v = ph[6] ? ~ph[5:0] : ph[5:0];
            osc_val[i] = signed'(8'({1'b0, tri_v, 1'b0} - ddc_front_pkg::TRI_OFFSET));
            osc_val[i][0] = osc_val[i][0] ^ (dither_on_ff[i] & lfsr_ff[i]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                phase_acc_ff[i] <= ddc_front_pkg::RST_WORD;
            end
            lfsr_ff <= ddc_front_pkg::LFSR_SEED;
        end else if (push) begin
            for (int i = 0; i < 3; i++) begin
                phase_acc_ff[i] <= 7'(phase_acc_ff[i] + tuning_word_ff[i]);
            end
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tone rotation; an invalid count of zero acts as one tone
    always_comb begin
        tones_eff = (tone_count_ff == 2'b00) ? 2'b01 : tone_count_ff;
        if (!burst_select_ff) begin
            tones_eff = 2'b01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tone_idx_ff <= 2'b00;
        end else if (wr_take && req_idx == ddc_front_pkg::IDX_DATAPATH) begin
            // restart rotation
            // Stale index could pick a tone beyond a smaller new count
            tone_idx_ff <= 2'b00;
        end else if (push) begin
            tone_idx_ff <= (2'(tone_idx_ff + 2'b01) >= tones_eff) ? 2'b00 : 2'(tone_idx_ff + 2'b01);
        end
    end

    assign osc_sel = osc_val[tone_idx_ff];
    assign prod = signed'(sample_i) * osc_sel;
    assign test_prod = ddc_front_pkg::TEST_CONST * osc_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Mixer and path selection
    always_comb begin
        case (ddc_front_pkg::mix_mode_t'(mix_mode_ff))
            ddc_front_pkg::MIX_NORMAL: mixed = prod[22:7];
            ddc_front_pkg::MIX_BYPASS: mixed = sample_i;
            ddc_front_pkg::MIX_TEST: mixed = test_prod[22:7];
            // Reserved code gives silence rather than stale data
            default: mixed = 16'h0000;
        endcase
        path_data = mixed;
        if (!burst_select_ff && j_input_source_select_ff) begin
            path_data = sample_i;
        end
    end

    assign buf_in = {burst_select_ff, tone_idx_ff, path_data};

    // Receiver stall fills the buffer and holds off the source
    ddc_skid_buf #(
        .W(ddc_front_pkg::BUF_W)
    ) u_out_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(buf_in),
        .in_valid_i(sample_valid_i),
        .in_ready_o(buf_ready),
        .out_data_o(buf_out),
        .out_valid_o(result_valid_o),
        .out_ready_i(result_ready_i)
    );

    assign sample_ready_o = buf_ready;
    assign result_o = buf_out[15:0];
    assign result_tone_o = buf_out[17:16];
    assign result_gh_path_o = buf_out[18];
    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o = rdata_ff;
    assign j_raw_source_o = j_input_source_select_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence bus_req_s;
        req && wait_ff;
    endsequence
    sequence bus_ans_s;
        !wait_ff ##1 wait_ff;
    endsequence

    AST_BUS_ONE_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_req_s |=> bus_ans_s) else $error("bus answer not after one wait");
    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (avs_read_i && !wait_ff) |-> (avs_readdata_o[31:8] == 24'h000000)) else $error("reserved bits not zero");
    AST_DITHER_RESET: assert property (@(posedge clk_i)
        $rose(rst_n_i) |-> (dither_on_ff == 3'b111)) else $error("dither enable not set after reset");
    AST_WORD_SEVEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_take && req_idx == ddc_front_pkg::IDX_OSC_FREQ[1])
        |=> (tuning_word_ff[1] == $past(avs_writedata_i[6:0]))) else $error("tuning word not stored");
    AST_PHASE_SEVEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_take && req_idx == ddc_front_pkg::IDX_OSC_PHASE[2])
        |=> (avs_readdata_o[7] == 1'b0) && (phase_shift_ff[2] == $past(avs_writedata_i[6:0])))
        else $error("phase offset not stored");
    AST_MIX_NORMAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (push && mix_mode_ff == 2'b00 && !(j_input_source_select_ff && !burst_select_ff) && !result_valid_o)
        |=> (result_valid_o && result_o == $past(mixed))) else $error("normal mixed word wrong");
    AST_MIX_BYPASS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (push && mix_mode_ff == 2'b01 && !result_valid_o) |=> (result_o == $past(sample_i)))
        else $error("bypass changed the sample");
    AST_MIX_TEST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mix_mode_ff == 2'b11 && burst_select_ff) |-> (path_data == test_prod[22:7]))
        else $error("test mode output wrong");
    AST_TONE_RANGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        burst_select_ff && tone_count_ff != 2'b00 |-> (tone_idx_ff < tone_count_ff) || $changed(tone_count_ff))
        else $error("tone index beyond count");
    AST_NONBURST_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (push && !burst_select_ff) |=> (tone_idx_ff == 2'b00)) else $error("tones used outside burst");
    AST_J_RAW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (push && !burst_select_ff && j_input_source_select_ff && !result_valid_o)
        |=> (result_o == $past(sample_i)) && !result_gh_path_o) else $error("J path not raw");
endmodule : ddc_front
`default_nettype wire

// ==== ddc_front_tb.sv ====
/*
 Self-checking bench of the down-conversion front: registers, mixer, tones, buffer.
 Assumes the package and design files are compiled first; one 40 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ddc_front_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [10:0] avs_address_i = 11'h000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [15:0] sample_i = 16'h0000;
    logic sample_valid_i = 1'b0;
    logic sample_ready_o;
    logic [15:0] result_o;
    logic result_gh_path_o;
    logic [1:0] result_tone_o;
    logic result_valid_o;
    logic result_ready_i = 1'b1;
    logic j_raw_source_o;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rr_mode = 0;
    int acc;
    logic [18:0] got_q [$];
    logic [15:0] sent_q [$];
    logic [31:0] rd;
    logic [15:0] v0;
    logic [15:0] v1;

    ddc_front ddc_front_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .sample_i(sample_i),
        .sample_valid_i(sample_valid_i),
        .sample_ready_o(sample_ready_o),
        .result_o(result_o),
        .result_gh_path_o(result_gh_path_o),
        .result_tone_o(result_tone_o),
        .result_valid_o(result_valid_o),
        .result_ready_i(result_ready_i),
        .j_raw_source_o(j_raw_source_o)
    );

    always #12.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////
    // Deterministic stall pattern keeps runs repeatable
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (result_valid_o === 1'b1 && result_ready_i === 1'b1)
            got_q.push_back({result_gh_path_o, result_tone_o, result_o});
        case (rr_mode)
            0: result_ready_i <= 1'b1;
            1: result_ready_i <= ((cycles % 3) != 0);
            default: result_ready_i <= 1'b0;
        endcase
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Test tone for a phase: centred triangle times the test constant
    function automatic logic [15:0] tone_exp(input int ph);
        int tri_v;
        tri_v = ((ph & 64) != 0) ? 63 - (ph & 63) : (ph & 63);
        return 16'(((tri_v * 2 - int'(ddc_front_pkg::TRI_OFFSET)) * int'(ddc_front_pkg::TEST_CONST)) >>> 7);
    endfunction : tone_exp

    ////////////////////////////////////////////////////////////////////////////
    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] d, input logic [3:0] be);
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {24'($urandom), d};
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clk_i);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hf);
    endtask : wr

    task automatic rdc(input string nm, input logic [8:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00, 4'hf);
        chk(nm, exp, rd);
    endtask : rdc

    ////////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [15:0] s);
        sample_i <= s;
        sample_valid_i <= 1'b1;
        sent_q.push_back(s);
        @(posedge clk_i);
        while (sample_ready_o !== 1'b1)
            @(posedge clk_i);
    endtask : send

    // Negative fix asks for random samples
    task automatic batch(input int n, input int fix);
        got_q.delete();
        sent_q.delete();
        for (int k = 0; k < n; k++)
            send(fix < 0 ? 16'($urandom) : 16'(fix));
        sample_valid_i <= 1'b0;
        for (int k = 0; k < 200 && got_q.size() < n; k++)
            @(posedge clk_i);
        @(posedge clk_i);
        chk("result_count", n, got_q.size());
    endtask : batch

    task automatic chk_stream(input int tones, input logic gh);
        for (int k = 0; k < got_q.size(); k++) begin
            chk("result", {16'h0000, sent_q[k]}, {16'h0000, got_q[k][15:0]});
            chk("tone", k % tones, got_q[k][17:16]);
            chk("gh_path", gh, got_q[k][18]);
        end
    endtask : chk_stream

    task automatic steady(input logic [15:0] exp);
        for (int k = 0; k < got_q.size(); k++)
            chk("osc_value", exp, got_q[k][15:0]);
    endtask : steady

    task automatic moves();
        logic differ;
        differ = 1'b0;
        for (int k = 1; k < got_q.size(); k++)
            if (got_q[k][15:0] !== got_q[0][15:0])
                differ = 1'b1;
        chk("osc_moves", 1, differ);
    endtask : moves

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf15aefe0));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 3; i++) begin
            rdc("dither", ddc_front_pkg::IDX_OSC_DITHER[i], 32'h01);
            rdc("tuning", ddc_front_pkg::IDX_OSC_FREQ[i], 32'h00);
            rdc("phase", ddc_front_pkg::IDX_OSC_PHASE[i], 32'h00);
            wr(ddc_front_pkg::IDX_OSC_DITHER[i], 8'hfe);
            wr(ddc_front_pkg::IDX_OSC_FREQ[i], 8'hff);
            wr(ddc_front_pkg::IDX_OSC_PHASE[i], 8'hff);
            rdc("dither", ddc_front_pkg::IDX_OSC_DITHER[i], 32'h00);
            rdc("tuning", ddc_front_pkg::IDX_OSC_FREQ[i], 32'h7f);
            rdc("phase", ddc_front_pkg::IDX_OSC_PHASE[i], 32'h7f);
            wr(ddc_front_pkg::IDX_OSC_FREQ[i], 8'h00);
            wr(ddc_front_pkg::IDX_OSC_PHASE[i], 8'h80);
        end
        rdc("mix", ddc_front_pkg::IDX_MIX_SELECT, 32'h00);
        rdc("dp", ddc_front_pkg::IDX_DATAPATH, 32'h64);
        chk("j_raw", 0, j_raw_source_o);
        wr(ddc_front_pkg::IDX_MIX_SELECT, 8'hff);
        wr(ddc_front_pkg::IDX_DATAPATH, 8'hff);
        rdc("mix", ddc_front_pkg::IDX_MIX_SELECT, 32'h03);
        rdc("dp", ddc_front_pkg::IDX_DATAPATH, 32'h74);
        chk("j_raw", 1, j_raw_source_o);
        wr(9'h101, 8'hff);
        rdc("unmapped", 9'h101, 32'h00);
        bus(1'b1, ddc_front_pkg::IDX_OSC_FREQ[0], 8'h55, 4'he);
        rdc("byte_off", ddc_front_pkg::IDX_OSC_FREQ[0], 32'h00);
        wr(ddc_front_pkg::IDX_MIX_SELECT, 8'h01);
        rr_mode = 1;
        for (int t = 1; t < 4; t++) begin
            wr(ddc_front_pkg::IDX_DATAPATH, 8'(t * 32 + 4));
            batch(7, -1);
            chk_stream(t, 1'b1);
        end
        wr(ddc_front_pkg::IDX_DATAPATH, 8'h60);
        batch(5, -1);
        chk_stream(1, 1'b0);
        wr(ddc_front_pkg::IDX_MIX_SELECT, 8'h03);
        wr(ddc_front_pkg::IDX_DATAPATH, 8'h70);
        batch(5, -1);
        chk_stream(1, 1'b0);
        wr(ddc_front_pkg::IDX_DATAPATH, 8'h60);
        rr_mode = 0;
        batch(4, 0);
        v0 = got_q[0][15:0];
        steady(v0);
        chk("test_lsb", 0, v0[6:0]);
        chk("test_val", tone_exp(0), v0);
        wr(ddc_front_pkg::IDX_OSC_PHASE[0], 8'h10);
        batch(4, 0);
        v1 = got_q[0][15:0];
        steady(v1);
        chk("phase_moves", 1, v1 !== v0);
        chk("phase_val", tone_exp(16), v1);
        wr(ddc_front_pkg::IDX_MIX_SELECT, 8'h00);
        batch(4, 16'h4000);
        steady(v1);
        batch(4, 0);
        steady(16'h0000);
        // Test tone ignores the sample; reserved code is never written
        wr(ddc_front_pkg::IDX_MIX_SELECT, 8'h03);
        batch(4, -1);
        steady(v1);
        wr(ddc_front_pkg::IDX_MIX_SELECT, 8'h03);
        wr(ddc_front_pkg::IDX_OSC_DITHER[0], 8'h01);
        batch(8, 0);
        moves();
        wr(ddc_front_pkg::IDX_OSC_DITHER[0], 8'h00);
        wr(ddc_front_pkg::IDX_OSC_FREQ[0], 8'h05);
        batch(8, 0);
        moves();
        // Buffer fill with receiver stalled, then drain
        wr(ddc_front_pkg::IDX_MIX_SELECT, 8'h01);
        rr_mode = 2;
        repeat (2) @(posedge clk_i);
        got_q.delete();
        sent_q.delete();
        acc = 0;
        sample_valid_i <= 1'b1;
        sample_i <= 16'($urandom);
        repeat (10) begin
            @(posedge clk_i);
            if (sample_ready_o === 1'b1) begin
                sent_q.push_back(sample_i);
                sample_i <= 16'($urandom);
                acc++;
            end
        end
        sample_valid_i <= 1'b0;
        chk("accepted", 2, acc);
        chk("full_ready", 0, sample_ready_o);
        rr_mode = 1;
        repeat (20) @(posedge clk_i);
        chk("drained", 2, got_q.size());
        chk_stream(1, 1'b0);
        // Second reset in mid-run
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdc("dp", ddc_front_pkg::IDX_DATAPATH, 32'h64);
        rdc("tuning", ddc_front_pkg::IDX_OSC_FREQ[0], 32'h00);
        complete_run();
    end
endmodule : ddc_front_tb
`default_nettype wire
